// ==== verilog/bcc_regs.svh ====
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

// Status codes, bit2..bit0
`define BCC_ST_IRQ_ACK 3'h0
`define BCC_ST_IO_READ 3'h1
`define BCC_ST_IO_WRITE 3'h2
`define BCC_ST_HALT 3'h3
`define BCC_ST_CODE_READ 3'h4
`define BCC_ST_MEM_READ 3'h5
`define BCC_ST_MEM_WRITE 3'h6
`define BCC_ST_PASSIVE 3'h7

// Bus-grant enable delay window in ns
`define BCC_GRANT_MIN_NS 110
`define BCC_GRANT_MAX_NS 250
`define BCC_CLK_PERIOD_NS 20
// Least time rounds up: ceil(110/20) = 6 cycles
`define BCC_GRANT_CYCLES ((`BCC_GRANT_MIN_NS + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
`define BCC_CNT_W 4

`endif

// ==== verilog/bcc_pkg.sv ====
package bcc_pkg;

    // Cycle kinds decoded from the status code
    typedef enum logic [2:0] {
        BCC_CYC_NONE,
        BCC_CYC_IRQ_ACK,
        BCC_CYC_IO_READ,
        BCC_CYC_IO_WRITE,
        BCC_CYC_MEM_READ,
        BCC_CYC_MEM_WRITE
    } bcc_cycle_e;

    // Command strobe bundle, all active low
    typedef struct packed {
        logic mem_read_n;
        logic mem_write_n;
        logic early_mem_write_n;
        logic io_read_n;
        logic io_write_n;
        logic early_io_write_n;
        logic irq_ack_n;
    } bcc_cmd_s;

    // Output enables of the command drivers, low while driving
    typedef struct packed {
        logic mem_oe_n;
        logic io_oe_n;
    } bcc_cmd_oe_s;

    // Control outputs
    typedef struct packed {
        logic addr_latch;
        logic xcvr_enable;
        logic xcvr_direction;
        logic cascade_or_periph_enable;
    } bcc_ctl_s;

endpackage : bcc_pkg

// ==== verilog/bcc_grant_timer.sv ====
`timescale 1ns/10ps
`include "bcc_regs.svh"

// Counts cycles since the bus grant went low; o_granted once the delay passed
module bcc_grant_timer #(
    parameter int CYCLES = `BCC_GRANT_CYCLES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Grant
    input wire logic i_bus_grant_n,
    output logic o_granted
);
    import bcc_pkg::*;

    localparam logic [`BCC_CNT_W-1:0] LIMIT = CYCLES[`BCC_CNT_W-1:0];

    typedef struct packed {
        logic [`BCC_CNT_W-1:0] cnt;
        logic granted;
    } bcc_tmr_s;

    bcc_tmr_s st_r;
    bcc_tmr_s st_nxt;

    // Grant released clears at once; output drops at the next clock and is not gated by the grant outside
    always_comb begin
        st_nxt = st_r;
        if (i_bus_grant_n) begin
            st_nxt.cnt = '0;
            st_nxt.granted = 1'b0;
        end else if (st_r.cnt != LIMIT) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else begin
            st_nxt.granted = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_granted = st_r.granted;

endmodule : bcc_grant_timer

// ==== verilog/bcc_ctrl.sv ====
`timescale 1ns/10ps
`include "bcc_regs.svh"

module bcc_ctrl (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Processor status and system inputs
    input wire logic [2:0] i_cycle_status_code,
    input wire logic i_bus_grant_n,
    input wire logic i_command_gate,
    input wire logic i_io_bus_strap,
    // Command strobes and their driver enables
    output bcc_pkg::bcc_cmd_s o_cmd,
    output bcc_pkg::bcc_cmd_oe_s o_cmd_oe,
    // Control outputs
    output bcc_pkg::bcc_ctl_s o_ctl
);
    import bcc_pkg::*;

    typedef enum logic [1:0] {
        BCC_IDLE,
        BCC_ADDR,
        BCC_EARLY,
        BCC_FULL
    } bcc_state_e;

    typedef struct packed {
        bcc_state_e state;
        bcc_cycle_e cycle;
        logic strap;
        bcc_cmd_s cmd;
        bcc_cmd_oe_s oe;
        bcc_ctl_s ctl;
    } bcc_st_s;

    localparam bcc_cmd_s CMD_IDLE = '1;

    bcc_st_s st_r;
    bcc_st_s st_nxt;
    logic granted;

    // Status decode, used at cycle start and to spot its end
    function automatic bcc_cycle_e decode(input logic [2:0] code);
        case (code)
            `BCC_ST_IRQ_ACK: decode = BCC_CYC_IRQ_ACK;
            `BCC_ST_IO_READ: decode = BCC_CYC_IO_READ;
            `BCC_ST_IO_WRITE: decode = BCC_CYC_IO_WRITE;
            `BCC_ST_CODE_READ: decode = BCC_CYC_MEM_READ;
            `BCC_ST_MEM_READ: decode = BCC_CYC_MEM_READ;
            `BCC_ST_MEM_WRITE: decode = BCC_CYC_MEM_WRITE;
            default: decode = BCC_CYC_NONE; // Halt and passive
        endcase
    endfunction : decode

    function automatic logic is_io(input bcc_cycle_e c);
        is_io = (c == BCC_CYC_IO_READ) || (c == BCC_CYC_IO_WRITE) || (c == BCC_CYC_IRQ_ACK);
    endfunction : is_io

    // Bus-grant delay, counted in whole clocks
    bcc_grant_timer #(
        .CYCLES(`BCC_GRANT_CYCLES)
    ) u_grant (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_bus_grant_n(i_bus_grant_n),
        .o_granted(granted)
    );

    // Sequencer: address phase, then read-timed strobes, then full write
    always_comb begin
        logic io_mode;
        logic cmd_ok;
        logic write;
        bcc_cycle_e dec;
        io_mode = st_r.strap;
        dec = decode(i_cycle_status_code);
        write = (st_r.cycle == BCC_CYC_IO_WRITE) || (st_r.cycle == BCC_CYC_MEM_WRITE);
        // I/O-bus mode lets I/O commands bypass arbitration
        cmd_ok = i_command_gate && ((io_mode && is_io(st_r.cycle)) || granted);
        st_nxt = st_r;
        st_nxt.ctl.addr_latch = 1'b0;
        // Drivers float when grant released, except I/O in I/O-bus mode
        st_nxt.oe.mem_oe_n = i_bus_grant_n;
        st_nxt.oe.io_oe_n = i_bus_grant_n && !st_r.strap;
        case (st_r.state)
            BCC_IDLE: begin
                st_nxt.cmd = CMD_IDLE;
                st_nxt.ctl.xcvr_enable = 1'b0;
                // Inactive level: cascade enable low, peripheral enable high
                st_nxt.ctl.cascade_or_periph_enable = st_r.strap;
                // Strap sampled only between cycles; a change on the start edge leaves the address-phase enables on the old strap
                st_nxt.strap = i_io_bus_strap;
                if (dec != BCC_CYC_NONE) begin
                    st_nxt.cycle = dec;
                    st_nxt.state = BCC_ADDR;
                    st_nxt.ctl.addr_latch = 1'b1;
                    // Direction set before enable and held for the cycle
                    st_nxt.ctl.xcvr_direction = (dec == BCC_CYC_IO_WRITE) ||
                        (dec == BCC_CYC_MEM_WRITE);
                    // Cascade enable only in system-bus ack cycle
                    if (!st_r.strap && dec == BCC_CYC_IRQ_ACK) begin
                        st_nxt.ctl.cascade_or_periph_enable = 1'b1;
                    end else begin
                        st_nxt.ctl.cascade_or_periph_enable = st_r.strap;
                    end
                end
            end
            BCC_ADDR: begin
                // Latch strobe falls here, after address settled
                st_nxt.state = BCC_EARLY;
                if (!st_r.strap) begin
                    st_nxt.ctl.cascade_or_periph_enable = 1'b0;
                end
            end
            BCC_EARLY, BCC_FULL: begin
                if (dec == BCC_CYC_NONE) begin
                    st_nxt.state = BCC_IDLE;
                    st_nxt.cmd = CMD_IDLE;
                    st_nxt.ctl.xcvr_enable = 1'b0;
                    st_nxt.ctl.cascade_or_periph_enable = st_r.strap;
                end else if (cmd_ok) begin
                    st_nxt.state = BCC_FULL;
                    case (st_r.cycle)
                        BCC_CYC_MEM_READ: st_nxt.cmd.mem_read_n = 1'b0;
                        BCC_CYC_MEM_WRITE: begin
                            st_nxt.cmd.early_mem_write_n = 1'b0;
                            // Normal write one phase after early write
                            st_nxt.cmd.mem_write_n = (st_r.state != BCC_FULL);
                        end
                        BCC_CYC_IO_READ: st_nxt.cmd.io_read_n = 1'b0;
                        BCC_CYC_IO_WRITE: begin
                            st_nxt.cmd.early_io_write_n = 1'b0;
                            st_nxt.cmd.io_write_n = (st_r.state != BCC_FULL);
                        end
                        BCC_CYC_IRQ_ACK: st_nxt.cmd.irq_ack_n = 1'b0;
                        default: st_nxt.cmd = CMD_IDLE;
                    endcase
                    // Peripheral enable serves I/O cycles in I/O-bus mode
                    if (st_r.strap && is_io(st_r.cycle)) begin
                        st_nxt.ctl.cascade_or_periph_enable = 1'b0;
                        st_nxt.ctl.xcvr_enable = 1'b0;
                    end else begin
                        st_nxt.ctl.xcvr_enable = 1'b1;
                    end
                end else begin
                    // Gate low or grant missing: all forced inactive
                    st_nxt.state = BCC_EARLY;
                    st_nxt.cmd = CMD_IDLE;
                    st_nxt.ctl.xcvr_enable = 1'b0;
                    st_nxt.ctl.cascade_or_periph_enable = st_r.strap;
                end
                if (write != st_nxt.ctl.xcvr_direction) begin
                    st_nxt.ctl.xcvr_direction = write;
                end
            end
            default: begin
                st_nxt.state = BCC_IDLE;
                st_nxt.cmd = CMD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r.state <= BCC_IDLE;
            st_r.cycle <= BCC_CYC_NONE;
            st_r.strap <= 1'b0;
            st_r.cmd <= '1;
            st_r.oe <= '1;
            st_r.ctl <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign o_cmd = st_r.cmd;
    assign o_cmd_oe = st_r.oe;
    assign o_ctl = st_r.ctl;

endmodule : bcc_ctrl

// ==== tb/bcc_ctrl_sva.sv ====
`timescale 1ns/10ps
module bcc_ctrl_sva (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Inputs
    input wire logic [2:0] i_cycle_status_code,
    input wire logic i_bus_grant_n,
    input wire logic i_command_gate,
    input wire logic i_io_bus_strap,
    // Outputs
    input wire bcc_pkg::bcc_cmd_s o_cmd,
    input wire bcc_pkg::bcc_cmd_oe_s o_cmd_oe,
    input wire bcc_pkg::bcc_ctl_s o_ctl
);
    import bcc_pkg::*;
    logic [3:0] low_r;
    // Grant low time, saturating so a long grant never wraps
    always_ff @(posedge i_core_clk) begin
        low_r <= i_bus_grant_n ? 4'h0 : low_r + {3'h0, low_r != 4'hF};
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    idle_release_a: assert property (i_cycle_status_code == 3'h7 |-> ##2 o_cmd == 7'h7F)
        else $error("strobe low while passive");
    gate_off_a: assert property (!i_command_gate [*2] |=> o_cmd == 7'h7F && !o_ctl.xcvr_enable)
        else $error("strobe active with gate low");
    latch_pulse_a: assert property ($rose(o_ctl.addr_latch) |=> !o_ctl.addr_latch)
        else $error("address latch pulse too long");
    dir_hold_a: assert property (o_ctl.xcvr_enable && $past(o_ctl.xcvr_enable) |-> $stable(o_ctl.xcvr_direction))
        else $error("direction moved while enabled");
    write_dir_a: assert property (!o_cmd.mem_write_n || !o_cmd.io_write_n |-> o_ctl.xcvr_direction)
        else $error("write without transmit");
    read_dir_a: assert property (!o_cmd.mem_read_n || !o_cmd.io_read_n |-> !o_ctl.xcvr_direction)
        else $error("read without receive");
    grant_min_a: assert property (!o_cmd_oe.mem_oe_n && !(o_cmd.mem_read_n && o_cmd.mem_write_n)
        |-> low_r >= 4'h6)
        else $error("memory strobe too soon after grant");
    early_first_a: assert property (!o_cmd.mem_write_n || !o_cmd.io_write_n
        |-> $past(!o_cmd.early_mem_write_n || !o_cmd.early_io_write_n))
        else $error("write before early write");
    ack_decode_a: assert property ($fell(o_cmd.irq_ack_n) |-> $past(i_cycle_status_code) == 3'h0)
        else $error("ack strobe for wrong status");
endmodule : bcc_ctrl_sva
bind bcc_ctrl bcc_ctrl_sva bcc_ctrl_sva_inst (.i_core_clk, .i_rst, .i_cycle_status_code,
    .i_bus_grant_n, .i_command_gate, .i_io_bus_strap, .o_cmd, .o_cmd_oe, .o_ctl);

// ==== tb/bcc_cpu_model.sv ====
`timescale 1ns/10ps
// Processor status source; holds one code for a set number of cycles
module bcc_cpu_model (
    // Clock
    input wire logic i_core_clk,
    // Request from the bench
    input wire logic i_start,
    input wire logic [2:0] i_code,
    input wire logic [3:0] i_len,
    // Status lines
    output logic [2:0] o_status
);
    logic [3:0] left_r = 4'h0;
    initial o_status = 3'h7;
    // Changes after the falling edge, clear of the sampling edge
    always @(negedge i_core_clk) begin
        if (left_r == 4'h0 && i_start) begin
            o_status <= i_code;
            left_r <= i_len;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) o_status <= 3'h7; // Passive between cycles
        end
    end
endmodule : bcc_cpu_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import bcc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic grant_n = 1'b1, gate = 1'b1, strap = 1'b0, start = 1'b0;
    logic [2:0] code = 3'h7, status;
    logic [3:0] len = 4'h8;
    bcc_cmd_s cmd;
    bcc_cmd_oe_s cmd_oe;
    bcc_ctl_s ctl;
    int fail_count = 0, n_tests = 0, n;
    // 50 MHz clock
    always #10 i_core_clk = ~i_core_clk;
    bcc_cpu_model bcc_cpu_model_inst (.i_core_clk, .i_start(start), .i_code(code),
        .i_len(len), .o_status(status));
    bcc_ctrl bcc_ctrl_inst (.i_core_clk, .i_rst, .i_cycle_status_code(status),
        .i_bus_grant_n(grant_n), .i_command_gate(gate), .i_io_bus_strap(strap),
        .o_cmd(cmd), .o_cmd_oe(cmd_oe), .o_ctl(ctl));
    task chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Strobe levels a cycle should reach; I/O ignores grant in I/O-bus mode
    function logic [6:0] exp_cmd(input logic [2:0] c, input logic s, g, gn);
        logic [6:0] m;
        case (c)
            3'h0: m = 7'h01;
            3'h1: m = 7'h08;
            3'h2: m = 7'h06;
            3'h4, 3'h5: m = 7'h40;
            3'h6: m = 7'h30;
            default: m = 7'h00;
        endcase
        return (g && (!gn || (s && !c[2]))) ? ~m : 7'h7F;
    endfunction : exp_cmd
    // One bus cycle; grant settles first so the delay is long past
    task run(input logic [2:0] c, input logic s, g, gn);
        logic [6:0] seen, e;
        logic xv, al, pa, dr;
        strap = s;
        gate = g;
        grant_n = gn;
        repeat (10) @(negedge i_core_clk);
        code = c;
        start <= 1'b1;
        @(negedge i_core_clk);
        start <= 1'b0;
        seen = 7'h7F;
        xv = 1'b0;
        al = 1'b0;
        pa = 1'b0;
        dr = 1'b0;
        repeat (12) begin
            @(negedge i_core_clk);
            seen &= cmd;
            xv |= ctl.xcvr_enable;
            al |= ctl.addr_latch;
            pa |= (ctl.cascade_or_periph_enable != s);
            if (ctl.addr_latch) dr = ctl.xcvr_direction;
        end
        e = exp_cmd(c, s, g, gn);
        chk("strobes", e, seen);
        chk("xcvr_enable", {6'h0, e != 7'h7F && !(s && !c[2])}, {6'h0, xv});
        if (e != 7'h7F) chk("addr_latch", 7'h01, {6'h0, al});
        chk("idle", 7'h7F, cmd);
        chk("dual_enable", {6'h0, s ? (e != 7'h7F && !c[2]) : (c == 3'h0)}, {6'h0, pa});
        chk("xcvr_direction", {6'h0, c == 3'h2 || c == 3'h6}, {6'h0, dr});
        chk("cmd_oe", {5'h0, gn, gn && !s}, {5'h0, cmd_oe});
    endtask : run
    task stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Main sequence: every code in both modes, then random mixes
    initial begin
        void'($urandom(32'hE56839F4));
        repeat (12) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst = 1'b0;
        for (int i = 0; i < 16; i++) run(3'(i), i[3], 1'b1, i[3]);
        for (int i = 0; i < 40; i++) run(3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
        strap = 1'b0;
        gate = 1'b1;
        grant_n = 1'b1;
        len = 4'hF;
        repeat (4) @(negedge i_core_clk);
        code = 3'h5;
        start <= 1'b1;
        @(negedge i_core_clk);
        start <= 1'b0;
        repeat (3) @(negedge i_core_clk);
        grant_n = 1'b0;
        n = 0;
        while (cmd.mem_read_n !== 1'b0 && n < 20) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk("grant_delay", 7'h01, {6'h0, n >= 6 && n <= 13});
        @(negedge i_core_clk);
        grant_n = 1'b1;
        @(posedge i_core_clk);
        #1;
        chk("mem_oe_n", 7'h01, {6'h0, cmd_oe.mem_oe_n});
        repeat (16) @(negedge i_core_clk);
        stop_test();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (5000) @(posedge i_core_clk);
        fail_count++;
        stop_test();
    end
endmodule : tb_top
